//--- common/dtg_pkg.sv
// Constants shared by both ends of the display timing synchronisation link.
// Assumes a single 25 MHz clock that feeds both ends.
package dtg_pkg;
	localparam int HW = 12;
	localparam int VW = 11;
	localparam int DW = 16;
	localparam int AW = 4;
	localparam int PIX_W = 24;
	localparam int SEED_W = 24;
	localparam int CTRL_W = 9;
	localparam int CLK_NS = 40;

	// Control register bit positions (device and host use the same layout)
	localparam int CTRL_RUN = 0;
	localparam int CTRL_OUTEN = 1;
	localparam int CTRL_LSYNC = 2;
	localparam int CTRL_FLOCK = 3;
	localparam int CTRL_BG_LSB = 4;
	localparam int CTRL_PLLSRC = 7;
	localparam int CTRL_ILACE = 8;

	// Device register indices on the link
	localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
	localparam logic [AW-1:0] ADDR_HTOTAL = 4'h1;
	localparam logic [AW-1:0] ADDR_VTOTAL = 4'h2;
	localparam logic [AW-1:0] ADDR_HLOCK = 4'h3;
	localparam logic [AW-1:0] ADDR_VLOCK = 4'h4;
	localparam logic [AW-1:0] ADDR_LPH = 4'h5;
	localparam logic [AW-1:0] ADDR_LPV = 4'h6;
	localparam logic [AW-1:0] ADDR_SEED_HI = 4'h7;
	localparam logic [AW-1:0] ADDR_SEED_MID = 4'h8;
	localparam logic [AW-1:0] ADDR_SEED_LO = 4'h9;
	localparam logic [AW-1:0] ADDR_LAST = 4'h9;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
	localparam logic [HW-1:0] HTOTAL_RST = 12'h320;
	localparam logic [VW-1:0] VTOTAL_RST = 11'h20d;
	localparam logic [2:0] SYNC_RST = 3'h7;

	// Fixed display geometry, in pixels and lines
	localparam logic [HW-1:0] HS_WIDTH = 12'h060;
	localparam logic [VW-1:0] VS_WIDTH = 11'h002;
	localparam logic [HW-1:0] H_BLANK = 12'h090;
	localparam logic [VW-1:0] V_BLANK = 11'h023;

	// Frame-sync pulse driven by the host, least width
	localparam int FS_PULSE_NS = 200;
	localparam logic [3:0] FS_PULSE_CYC = 4'((FS_PULSE_NS + CLK_NS - 1) / CLK_NS);

	// Host Wishbone byte offsets
	localparam logic [7:0] WB_CTRL = 8'h00;
	localparam logic [7:0] WB_HTOTAL = 8'h04;
	localparam logic [7:0] WB_VTOTAL = 8'h08;
	localparam logic [7:0] WB_LOCKPT = 8'h0c;
	localparam logic [7:0] WB_SEED = 8'h10;
	localparam logic [7:0] WB_CMD = 8'h14;
	localparam logic [7:0] WB_STATUS = 8'h18;

	// Mode code is {line_sync_enable, frame_lock_enable}
	typedef enum logic [1:0] {
		MODE_CLOCK = 2'b00,
		MODE_FRAME = 2'b01,
		MODE_LINE = 2'b10,
		MODE_FREE = 2'b11
	} mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} dtg_state_t;
endpackage : dtg_pkg

//--- common/dtg_link_if.sv
// Link between the display timing device and the external system.
// Both ends share one clock, supplied to each module separately.
`timescale 1ns/1ps
`default_nettype none
interface dtg_link_if;
	logic reg_wr;
	logic [dtg_pkg::AW-1:0] reg_addr;
	logic [dtg_pkg::DW-1:0] reg_wdata;
	logic [dtg_pkg::DW-1:0] reg_rdata;
	logic ext_fsync_n;
	logic pll_locked;
	logic [dtg_pkg::HW-1:0] in_hpos;
	logic [dtg_pkg::VW-1:0] in_vpos;
	logic in_odd;
	logic in_line;
	logic [dtg_pkg::PIX_W-1:0] in_pixel;
	logic buf_err;
	logic display_vsync;
	logic overlay_vsync;
	logic input_line_request;
	logic input_composite_blank;

	modport dev (
		input reg_wr, reg_addr, reg_wdata, ext_fsync_n, pll_locked,
		input in_hpos, in_vpos, in_odd, in_line, in_pixel, buf_err,
		output reg_rdata, display_vsync, overlay_vsync, input_line_request, input_composite_blank
	);
	modport host (
		output reg_wr, reg_addr, reg_wdata, ext_fsync_n, pll_locked,
		output in_hpos, in_vpos, in_odd, in_line, in_pixel, buf_err,
		input reg_rdata, display_vsync, overlay_vsync, input_line_request, input_composite_blank
	);
endinterface : dtg_link_if
`default_nettype wire

//--- design/dtg_sync_device.sv
// Display timing generator with its synchronisation control.
// Assumes the link host end on the same clock; frame-sync and lock pins arrive asynchronously.
// Summary of operation
// - Free run starts timing at run enable
// - Free run ignores frame-sync and lock point
// - System decides frame start, feeds data promptly
// - Other modes wait for start event after enable
// - Start event loads lock-load position at once
// - Frame sync reloads position on each event
// - Reference clock tracks input; frame periods equal
// - Frame sync: hlock half total, vlock total
// - Interlaced: odd field only locks timing
// - Line sync reloads on lock point, sync fall
// - Line sync synthesises line rate from seed
// - Line sync horizontal total exceeds longest line
// - Line sync: hlock total minus one
// - Line sync needs line-locked input clock
// - Clock sync: external clock keeps frame lock
// - Clock sync: only frame-sync pin reloads position
// - Buffer error shows background colour rest of frame
// - Normal output resumes at next frame
// - Lock loss honoured only with PLL source
// - Lock loss clears control, halts, clamps outputs
// - Host rewrites control after lock loss
// - Two control bits select the mode
// - Lock point once per frame, zero disables
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dtg_sync_device (
	input wire logic clk_i,
	input wire logic rst_i,
	dtg_link_if.dev link,
	output logic [dtg_pkg::PIX_W-1:0] disp_pixel_o,
	output logic disp_hsync_o,
	output logic disp_vsync_o,
	output logic disp_den_o
);
	logic [dtg_pkg::CTRL_W-1:0] ctrl_q;
	logic [dtg_pkg::CTRL_W-1:0] ctrl_d;
	logic [dtg_pkg::HW-1:0] htotal_q;
	logic [dtg_pkg::HW-1:0] hlock_q;
	logic [dtg_pkg::HW-1:0] lph_q;
	logic [dtg_pkg::VW-1:0] vtotal_q;
	logic [dtg_pkg::VW-1:0] vlock_q;
	logic [dtg_pkg::VW-1:0] lpv_q;
	logic [7:0] seed_hi_q;
	logic [7:0] seed_mid_q;
	logic [7:0] seed_lo_q;
	logic [2:0] fs_sync_q;
	logic [2:0] lk_sync_q;
	logic fs_lvl_q;
	logic lk_lvl_q;
	logic run_q;
	logic lp_match_q;
	logic err_q;
	logic [dtg_pkg::SEED_W-1:0] acc_q;
	logic [dtg_pkg::HW-1:0] hcnt_q;
	logic [dtg_pkg::VW-1:0] vcnt_q;
	dtg_pkg::dtg_state_t st_q;
	dtg_pkg::dtg_state_t st_d;
	dtg_pkg::mode_t mode;
	logic hsync_q;
	logic vsync_q;
	logic ovs_q;
	logic lreq_q;
	logic blank_q;

	// Register write decode
	wire wr_ctrl = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_CTRL);
	wire wr_htot = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_HTOTAL);
	wire wr_vtot = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_VTOTAL);
	wire wr_hlock = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_HLOCK);
	wire wr_vlock = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_VLOCK);
	wire wr_lph = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_LPH);
	wire wr_lpv = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_LPV);
	wire wr_shi = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_SEED_HI);
	wire wr_smid = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_SEED_MID);
	wire wr_slo = link.reg_wr && (link.reg_addr == dtg_pkg::ADDR_SEED_LO);

	// Timing geometry registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			htotal_q <= dtg_pkg::HTOTAL_RST;
			vtotal_q <= dtg_pkg::VTOTAL_RST;
			hlock_q <= '0;
			vlock_q <= '0;
			lph_q <= '0;
			lpv_q <= '0;
		end else begin
			if (wr_htot) htotal_q <= link.reg_wdata[dtg_pkg::HW-1:0];
			if (wr_vtot) vtotal_q <= link.reg_wdata[dtg_pkg::VW-1:0];
			if (wr_hlock) hlock_q <= link.reg_wdata[dtg_pkg::HW-1:0];
			if (wr_vlock) vlock_q <= link.reg_wdata[dtg_pkg::VW-1:0];
			if (wr_lph) lph_q <= link.reg_wdata[dtg_pkg::HW-1:0];
			if (wr_lpv) lpv_q <= link.reg_wdata[dtg_pkg::VW-1:0];
		end
	end

	// Line rate seed, split over three byte registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seed_hi_q <= '0;
			seed_mid_q <= '0;
			seed_lo_q <= '0;
		end else begin
			if (wr_shi) seed_hi_q <= link.reg_wdata[7:0];
			if (wr_smid) seed_mid_q <= link.reg_wdata[7:0];
			if (wr_slo) seed_lo_q <= link.reg_wdata[7:0];
		end
	end

	// Pin synchronisers; a new level counts once stages two and three agree
	wire fs_lvl_d = (fs_sync_q[1] == fs_sync_q[2]) ? fs_sync_q[2] : fs_lvl_q;
	wire lk_lvl_d = (lk_sync_q[1] == lk_sync_q[2]) ? lk_sync_q[2] : lk_lvl_q;
	wire fs_event = fs_lvl_q & ~fs_lvl_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fs_sync_q <= dtg_pkg::SYNC_RST;
			lk_sync_q <= dtg_pkg::SYNC_RST;
			fs_lvl_q <= 1'b1;
			lk_lvl_q <= 1'b1;
		end else begin
			fs_sync_q <= {fs_sync_q[1:0], link.ext_fsync_n};
			lk_sync_q <= {lk_sync_q[1:0], link.pll_locked};
			fs_lvl_q <= fs_lvl_d;
			lk_lvl_q <= lk_lvl_d;
		end
	end

	// Lock loss wins over a software write; only armed with the PLL source
	wire pll_lost = ctrl_q[dtg_pkg::CTRL_PLLSRC] & ~lk_lvl_q;
	assign ctrl_d = pll_lost ? dtg_pkg::CTRL_RST : (wr_ctrl ? link.reg_wdata[dtg_pkg::CTRL_W-1:0] : ctrl_q);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= dtg_pkg::CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Mode and event decode
	wire run = ctrl_q[dtg_pkg::CTRL_RUN];
	wire run_rise = run & ~run_q;
	assign mode = dtg_pkg::mode_t'({ctrl_q[dtg_pkg::CTRL_LSYNC], ctrl_q[dtg_pkg::CTRL_FLOCK]});
	wire lp_armed = (lph_q != '0) || (lpv_q != '0);
	wire lp_field = ~ctrl_q[dtg_pkg::CTRL_ILACE] | link.in_odd;
	wire lp_match = lp_armed && lp_field && (link.in_hpos == lph_q) && (link.in_vpos == lpv_q);
	wire lock_pt = lp_match & ~lp_match_q;
	wire start_ev = lock_pt | fs_event;
	wire sync_ev = (mode == dtg_pkg::MODE_FRAME) || (mode == dtg_pkg::MODE_LINE);
	wire resync_ev = sync_ev ? start_ev : ((mode == dtg_pkg::MODE_CLOCK) & fs_event);
	wire running = (st_q == dtg_pkg::ST_RUN);

	// Start-up sequencing; free run skips the wait for a start event
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			dtg_pkg::ST_IDLE: begin
				if (run_rise) st_d = (mode == dtg_pkg::MODE_FREE) ? dtg_pkg::ST_RUN : dtg_pkg::ST_WAIT;
			end
			dtg_pkg::ST_WAIT: begin
				if (start_ev) st_d = dtg_pkg::ST_RUN;
			end
			dtg_pkg::ST_RUN: begin
				st_d = dtg_pkg::ST_RUN;
			end
		endcase
		if (!run) st_d = dtg_pkg::ST_IDLE;
	end

	// Line rate synthesiser: phase accumulator realigned on each input line
	wire [dtg_pkg::SEED_W-1:0] seed = {seed_hi_q, seed_mid_q, seed_lo_q};
	wire [dtg_pkg::SEED_W:0] acc_sum = {1'b0, acc_q} + {1'b0, seed};
	wire synth_end = (mode == dtg_pkg::MODE_LINE) & acc_sum[dtg_pkg::SEED_W];

	// Counters; the start event and later resyncs jump straight to the lock-load position
	wire load_pos = ((st_q == dtg_pkg::ST_WAIT) & start_ev) | (running & resync_ev);
	wire h_wrap = hcnt_q >= (htotal_q - dtg_pkg::HW'(1));
	wire v_wrap = vcnt_q >= (vtotal_q - dtg_pkg::VW'(1));
	wire line_end = running & (h_wrap | synth_end);
	wire frame_start = line_end & v_wrap;
	wire [dtg_pkg::HW-1:0] hcnt_d = load_pos ? hlock_q : ((!running || line_end) ? '0 : hcnt_q + dtg_pkg::HW'(1));
	wire [dtg_pkg::VW-1:0] vcnt_next = v_wrap ? '0 : vcnt_q + dtg_pkg::VW'(1);
	wire [dtg_pkg::VW-1:0] vcnt_d = load_pos ? vlock_q : (!running ? '0 : (line_end ? vcnt_next : vcnt_q));
	// A buffer error arriving on the frame boundary still wins over the clear
	wire err_d = link.buf_err | (err_q & ~frame_start);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= dtg_pkg::ST_IDLE;
			run_q <= 1'b0;
			lp_match_q <= 1'b0;
			acc_q <= '0;
			hcnt_q <= '0;
			vcnt_q <= '0;
			err_q <= 1'b0;
		end else begin
			st_q <= st_d;
			run_q <= run;
			lp_match_q <= lp_match;
			acc_q <= link.in_line ? '0 : acc_sum[dtg_pkg::SEED_W-1:0];
			hcnt_q <= hcnt_d;
			vcnt_q <= vcnt_d;
			err_q <= err_d;
		end
	end

	// Display outputs are clamped low unless running with outputs enabled; overlay vsync, line request and blank need only running
	wire drive = running & ctrl_q[dtg_pkg::CTRL_OUTEN];
	wire [2:0] bg = ctrl_q[dtg_pkg::CTRL_BG_LSB +: 3];
	wire [dtg_pkg::PIX_W-1:0] bg_rgb = {{8{bg[2]}}, {8{bg[1]}}, {8{bg[0]}}};
	wire den_now = (hcnt_q >= dtg_pkg::H_BLANK) && (vcnt_q >= dtg_pkg::V_BLANK);
	wire [dtg_pkg::PIX_W-1:0] pix_sel = err_q ? bg_rgb : link.in_pixel;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disp_pixel_o <= '0;
			disp_den_o <= 1'b0;
			hsync_q <= 1'b0;
			vsync_q <= 1'b0;
			ovs_q <= 1'b0;
			lreq_q <= 1'b0;
			blank_q <= 1'b0;
		end else begin
			disp_pixel_o <= (drive & den_now) ? pix_sel : '0;
			disp_den_o <= drive & den_now;
			hsync_q <= drive & (hcnt_q < dtg_pkg::HS_WIDTH);
			vsync_q <= drive & (vcnt_q < dtg_pkg::VS_WIDTH);
			ovs_q <= running & (vcnt_q < dtg_pkg::VS_WIDTH); // Overlay keeps running through a buffer error
			lreq_q <= running & line_end;
			blank_q <= running & ~den_now;
		end
	end

	// Link outputs; readback shows control plus live state
	assign disp_hsync_o = hsync_q;
	assign disp_vsync_o = vsync_q;
	assign link.display_vsync = vsync_q;
	assign link.overlay_vsync = ovs_q;
	assign link.input_line_request = lreq_q;
	assign link.input_composite_blank = blank_q;
	assign link.reg_rdata = {err_q, running, st_q == dtg_pkg::ST_WAIT, 4'h0, ctrl_q};
endmodule : dtg_sync_device
`default_nettype wire

//--- design/dtg_sync_host.sv
// External system end: Wishbone registers for software, a sequencer that loads the
// device registers over the link, frame-sync pulse generation and lock-loss restart.
// Assumes video timing, pixels and PLL lock come from user logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dtg_sync_host (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pll_locked_i,
	input wire logic [dtg_pkg::HW-1:0] in_hpos_i,
	input wire logic [dtg_pkg::VW-1:0] in_vpos_i,
	input wire logic in_odd_i,
	input wire logic in_line_i,
	input wire logic [dtg_pkg::PIX_W-1:0] in_pixel_i,
	input wire logic buf_err_i,
	dtg_link_if.host link
);
	logic [31:0] ctrl_w_q;
	logic [31:0] htot_w_q;
	logic [31:0] vtot_w_q;
	logic [31:0] lock_w_q;
	logic [31:0] seed_w_q;
	logic newframe_q;
	logic loss_q;
	logic vs_q;
	logic pend_q;
	logic busy_q;
	logic [dtg_pkg::AW-1:0] idx_q;
	logic [3:0] fs_cnt_q;
	logic fsn_q;
	logic plk_q;
	logic [dtg_pkg::DW-1:0] dev_word [0:9];

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge

	// Wishbone decode; every access is answered one edge after it is taken
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i;
	wire wr_ctrl = wr && (wb_adr_i == dtg_pkg::WB_CTRL);
	wire wr_htot = wr && (wb_adr_i == dtg_pkg::WB_HTOTAL);
	wire wr_vtot = wr && (wb_adr_i == dtg_pkg::WB_VTOTAL);
	wire wr_lock = wr && (wb_adr_i == dtg_pkg::WB_LOCKPT);
	wire wr_seed = wr && (wb_adr_i == dtg_pkg::WB_SEED);
	wire wr_cmd = wr && (wb_adr_i == dtg_pkg::WB_CMD) && wb_sel_i[0];
	wire wr_stat = wr && (wb_adr_i == dtg_pkg::WB_STATUS) && wb_sel_i[0];
	wire cfg_wr = wr_ctrl | wr_htot | wr_vtot | wr_lock | wr_seed;
	wire [31:0] status = {link.reg_rdata, 13'h0000, busy_q, loss_q, newframe_q};
	wire [31:0] rd_mux = (wb_adr_i == dtg_pkg::WB_CTRL) ? ctrl_w_q :
		(wb_adr_i == dtg_pkg::WB_HTOTAL) ? htot_w_q :
		(wb_adr_i == dtg_pkg::WB_VTOTAL) ? vtot_w_q :
		(wb_adr_i == dtg_pkg::WB_LOCKPT) ? lock_w_q :
		(wb_adr_i == dtg_pkg::WB_SEED) ? seed_w_q :
		(wb_adr_i == dtg_pkg::WB_STATUS) ? status : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			ctrl_w_q <= '0;
			htot_w_q <= 32'(dtg_pkg::HTOTAL_RST);
			vtot_w_q <= 32'(dtg_pkg::VTOTAL_RST);
			lock_w_q <= '0;
			seed_w_q <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= (req & ~wb_we_i) ? rd_mux : '0;
			if (wr_ctrl) ctrl_w_q <= merge(ctrl_w_q, wb_dat_i, wb_sel_i) & 32'h0000_01ff;
			if (wr_htot) htot_w_q <= merge(htot_w_q, wb_dat_i, wb_sel_i) & 32'h0000_0fff;
			if (wr_vtot) vtot_w_q <= merge(vtot_w_q, wb_dat_i, wb_sel_i) & 32'h0000_07ff;
			if (wr_lock) lock_w_q <= merge(lock_w_q, wb_dat_i, wb_sel_i) & 32'h07ff_0fff;
			if (wr_seed) seed_w_q <= merge(seed_w_q, wb_dat_i, wb_sel_i) & 32'h00ff_ffff;
		end
	end

	// Lock-load positions follow the recommended settings for the chosen mode
	wire [dtg_pkg::HW-1:0] htot = htot_w_q[dtg_pkg::HW-1:0];
	wire [dtg_pkg::VW-1:0] vtot = vtot_w_q[dtg_pkg::VW-1:0];
	wire line_mode = ctrl_w_q[dtg_pkg::CTRL_LSYNC] & ~ctrl_w_q[dtg_pkg::CTRL_FLOCK];
	wire [dtg_pkg::HW-1:0] hlock = line_mode ? htot - dtg_pkg::HW'(1) : {1'b0, htot[dtg_pkg::HW-1:1]};
	assign dev_word[dtg_pkg::ADDR_CTRL] = {7'h00, ctrl_w_q[dtg_pkg::CTRL_W-1:0]};
	assign dev_word[dtg_pkg::ADDR_HTOTAL] = {4'h0, htot};
	assign dev_word[dtg_pkg::ADDR_VTOTAL] = {5'h00, vtot};
	assign dev_word[dtg_pkg::ADDR_HLOCK] = {4'h0, hlock};
	assign dev_word[dtg_pkg::ADDR_VLOCK] = {5'h00, vtot};
	assign dev_word[dtg_pkg::ADDR_LPH] = {4'h0, lock_w_q[11:0]};
	assign dev_word[dtg_pkg::ADDR_LPV] = {5'h00, lock_w_q[26:16]};
	assign dev_word[dtg_pkg::ADDR_SEED_HI] = {8'h00, seed_w_q[23:16]};
	assign dev_word[dtg_pkg::ADDR_SEED_MID] = {8'h00, seed_w_q[15:8]};
	assign dev_word[dtg_pkg::ADDR_SEED_LO] = {8'h00, seed_w_q[7:0]};

	// Device stopped although software wants it running: lock was lost
	wire dev_run = link.reg_rdata[dtg_pkg::CTRL_RUN];
	wire loss_cond = ctrl_w_q[dtg_pkg::CTRL_RUN] & ~dev_run & ~busy_q & ~pend_q;
	wire start_seq = pend_q & ~busy_q;
	wire pend_d = cfg_wr | (loss_cond & plk_q) | (pend_q & ~start_seq);
	wire vs_rise = link.display_vsync & ~vs_q;

	// Sequencer: geometry first, control last, so the run edge sees the new values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= 1'b0;
			busy_q <= 1'b0;
			idx_q <= dtg_pkg::ADDR_HTOTAL;
		end else begin
			pend_q <= pend_d;
			if (start_seq) begin
				busy_q <= 1'b1;
				idx_q <= dtg_pkg::ADDR_HTOTAL;
			end else if (busy_q) begin
				busy_q <= (idx_q != dtg_pkg::ADDR_CTRL);
				idx_q <= (idx_q == dtg_pkg::ADDR_LAST) ? dtg_pkg::ADDR_CTRL : idx_q + dtg_pkg::AW'(1);
			end
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			newframe_q <= 1'b0;
			loss_q <= 1'b0;
			vs_q <= 1'b0;
		end else begin
			vs_q <= link.display_vsync;
			newframe_q <= vs_rise | (newframe_q & ~(wr_stat & wb_dat_i[0]));
			loss_q <= loss_cond | (loss_q & ~(wr_stat & wb_dat_i[1]));
		end
	end

	// Frame-sync pin: active-low pulse long enough for the three-stage synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fs_cnt_q <= '0;
			fsn_q <= 1'b1;
		end else begin
			fs_cnt_q <= (wr_cmd & wb_dat_i[0]) ? dtg_pkg::FS_PULSE_CYC : ((fs_cnt_q != 4'h0) ? fs_cnt_q - 4'h1 : 4'h0);
			fsn_q <= (fs_cnt_q == 4'h0);
		end
	end

	// Input video and PLL status forwarded one stage; clocks must track per mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			plk_q <= 1'b1;
			link.in_hpos <= '0;
			link.in_vpos <= '0;
			link.in_odd <= 1'b0;
			link.in_line <= 1'b0;
			link.in_pixel <= '0;
			link.buf_err <= 1'b0;
		end else begin
			plk_q <= pll_locked_i;
			link.in_hpos <= in_hpos_i;
			link.in_vpos <= in_vpos_i;
			link.in_odd <= in_odd_i;
			link.in_line <= in_line_i;
			link.in_pixel <= in_pixel_i;
			link.buf_err <= buf_err_i;
		end
	end

	assign link.reg_wr = busy_q;
	assign link.reg_addr = idx_q;
	assign link.reg_wdata = dev_word[idx_q];
	assign link.ext_fsync_n = fsn_q;
	assign link.pll_locked = plk_q;
endmodule : dtg_sync_host
`default_nettype wire

//--- tb/link_rules_sva.sv
// Checker for the link between the timing device and the system end.
// Assumes the link signals, the shared clock and the reset arrive as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module link_rules_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reg_wr,
	input wire logic [dtg_pkg::AW-1:0] reg_addr,
	input wire logic [dtg_pkg::DW-1:0] reg_wdata,
	input wire logic [dtg_pkg::DW-1:0] reg_rdata,
	input wire logic ext_fsync_n,
	input wire logic pll_locked,
	input wire logic buf_err,
	input wire logic display_vsync
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Readback is {err, running, waiting, 4'h0, ctrl}
	reset_clear_a: assert property (disable iff (1'b0) rst_i |=> reg_rdata == 16'h0000)
		else $error("readback not clear");
	lock_clear_a: assert property ($fell(pll_locked) && reg_rdata[7] ##1 (!pll_locked) [*6] |-> reg_rdata[8:0] == 9'h000)
		else $error("control kept on lock loss");
	lock_ignored_a: assert property (!reg_rdata[7] && reg_rdata[0] && !pll_locked && !reg_wr |=> reg_rdata[0])
		else $error("lock loss honoured without pll source");
	// Two idle samples leave room for the one-cycle output gate
	vsync_clamp_a: assert property ((reg_rdata[1:0] == 2'b00) [*2] |=> !display_vsync)
		else $error("vsync not clamped");
	ctrl_echo_a: assert property (reg_wr && reg_addr == dtg_pkg::ADDR_CTRL && pll_locked
		|=> reg_rdata[8:0] == $past(reg_wdata[8:0])) else $error("ctrl readback wrong");
	load_order_a: assert property (reg_wr && reg_addr == dtg_pkg::ADDR_HTOTAL
		|=> reg_wr [*8] ##1 (reg_wr && reg_addr == dtg_pkg::ADDR_CTRL)) else $error("load order wrong");
	free_run_a: assert property ($rose(reg_rdata[0]) && reg_rdata[3:2] == 2'b11 |-> ##[0:2] reg_rdata[14])
		else $error("free run did not start");
	err_set_a: assert property (buf_err && reg_rdata[14] |-> ##[1:2] reg_rdata[15])
		else $error("buffer error not flagged");
	fsync_width_a: assert property ($fell(ext_fsync_n) |-> (!ext_fsync_n) [*5] ##1 ext_fsync_n)
		else $error("frame sync pulse width wrong");

	cover property ($fell(ext_fsync_n));
	cover property ($rose(reg_rdata[15]));
	cover property ($fell(pll_locked) ##6 reg_rdata[8:0] == 9'h000);
endmodule : link_rules_sva
`default_nettype wire

//--- tb/display_timing_sync_control_tb_top.sv
// Bench: both ends joined by the link, software side driven over Wishbone.
// Assumes one 25 MHz clock; the frame is shortened through the total registers.
`timescale 1ns/1ps
`default_nettype none
module display_timing_sync_control_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pll = 1'b1, berr = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic ack, hs, vs, den;
	logic [23:0] dpix;
	logic [8:0] c;
	logic [15:0] lf = 16'h004a;
	int failures = 0, n_compared = 0, cyc_n = 0;
	dtg_link_if lnk ();

	dtg_sync_host u_dtg_sync_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pll_locked_i(pll),
		.in_hpos_i(lf[11:0]), .in_vpos_i(lf[10:0]), .in_odd_i(lf[0]), .in_line_i(lf[4:0] == 5'h00),
		.in_pixel_i({lf, lf[7:0]}), .buf_err_i(berr), .link(lnk.host));
	dtg_sync_device u_dtg_sync_device (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.dev), .disp_pixel_o(dpix),
		.disp_hsync_o(hs), .disp_vsync_o(vs), .disp_den_o(den));
	link_rules_sva chk (.clk_i(clk_i), .rst_i(rst_i), .reg_wr(lnk.reg_wr), .reg_addr(lnk.reg_addr),
		.reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .ext_fsync_n(lnk.ext_fsync_n),
		.pll_locked(lnk.pll_locked), .buf_err(lnk.buf_err), .display_vsync(lnk.display_vsync));

	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt

	// Model of the readback: free run starts at once, other modes wait for an event
	function automatic logic [15:0] dev_stat(input logic [8:0] k, input logic ev, input logic er);
		logic run;
		run = k[0] && (k[3:2] == 2'b11 || ev);
		return {er, run, k[0] && !run, 4'h0, k};
	endfunction : dev_stat

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Classic cycle; ack is read as sampled at the edge, before that edge's updates land
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 20) failures++; // A missing answer counts as a mismatch
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// Ten link writes follow each config write
	task automatic settle();
		repeat (14) @(posedge clk_i);
	endtask : settle

	task automatic rs();
		wb(1'b0, dtg_pkg::WB_STATUS, 32'h0);
	endtask : rs

	// Waits for a fresh rise of den (w=1) or of display vsync (w=0)
	task automatic wait_hi(input logic w);
		int n;
		n = 0;
		while ((w ? den : lnk.display_vsync) !== 1'b0 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		while ((w ? den : lnk.display_vsync) !== 1'b1 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 20000) failures++; // A rise that never comes counts as a mismatch
	endtask : wait_hi

	// Clock, random source and hang guard
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		lf <= nxt(lf);
		cyc_n <= cyc_n + 1;
		if (cyc_n == 60000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, dtg_pkg::WB_CTRL, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, 8'h1c, 32'h0);
		check(rd, 32'h0);
		wb(1'b1, dtg_pkg::WB_HTOTAL, 32'd200);
		wb(1'b1, dtg_pkg::WB_VTOTAL, 32'd40);
		wb(1'b1, dtg_pkg::WB_LOCKPT, 32'h0);
		wb(1'b0, dtg_pkg::WB_HTOTAL, 32'h0);
		check(rd, 32'd200);
		// Every mode: start from stop; all but free run wait until the frame-sync pin starts them
		for (int m = 0; m < 4; m++) begin
			c = {5'h00, m[0], m[1], 2'b11};
			wb(1'b1, dtg_pkg::WB_CTRL, 32'h0);
			settle();
			wb(1'b1, dtg_pkg::WB_CTRL, {23'h0, c});
			settle();
			rs();
			check(rd >> 16, {16'h0, dev_stat(c, 1'b0, 1'b0)});
			wb(1'b1, dtg_pkg::WB_CMD, 32'h1);
			settle();
			rs();
			check(rd >> 16, {16'h0, dev_stat(c, 1'b1, 1'b0)});
		end
		// Buffer error just after the vsync rise in free run, background colour 5
		c = 9'h05f;
		wb(1'b1, dtg_pkg::WB_CTRL, {23'h0, c});
		wait_hi(1'b0);
		berr <= 1'b1;
		@(posedge clk_i);
		berr <= 1'b0;
		wait_hi(1'b1);
		check({8'h00, dpix}, 32'h00ff00ff);
		rs();
		check(rd >> 16, {16'h0, dev_stat(c, 1'b1, 1'b1)});
		wait_hi(1'b0);
		check({31'h0, lnk.overlay_vsync}, 32'h1);
		settle();
		rs();
		check(rd >> 16, {16'h0, dev_stat(c, 1'b1, 1'b0)});
		// Lock loss without, then with, the pll clock source
		pll <= 1'b0;
		settle();
		rs();
		check(rd >> 16, {16'h0, dev_stat(c, 1'b1, 1'b0)});
		pll <= 1'b1;
		c = 9'h0df;
		wb(1'b1, dtg_pkg::WB_CTRL, {23'h0, c});
		settle();
		pll <= 1'b0;
		settle();
		rs();
		check({rd[31:16], 14'h0, rd[1], 1'b0}, 32'h00000002);
		check({5'h00, dpix, hs, vs, den}, 32'h0);
		check({29'h0, lnk.overlay_vsync, lnk.input_line_request, lnk.input_composite_blank}, 32'h0);
		pll <= 1'b1;
		repeat (40) @(posedge clk_i);
		rs();
		check(rd >> 16, {16'h0, dev_stat(c, 1'b1, 1'b0)});
		// Loss flag and new-frame flag clear on write-one once the device runs again
		wb(1'b1, dtg_pkg::WB_STATUS, 32'h3);
		rs();
		check({29'h0, rd[2:0]}, 32'h0);
		final_report();
	end
endmodule : display_timing_sync_control_tb_top
`default_nettype wire
